// ===== rtl/dev_caps_pkg.sv
// package: register map, field layout and carriers for the device capabilities two block
package dev_caps_pkg;

   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] DEVICE_CAPABILITIES_TWO_OFS = 8'h24;
   localparam logic [7:0] MALFORMED_COUNT_OFS         = 8'h40;
   localparam logic [7:0] RX_CONTROL_OFS              = 8'h44;
   localparam logic [7:0] RX_STATUS_OFS               = 8'h48;

   // ==========================================================
   // field positions of device_capabilities_two
   localparam int MAX_PREFIX_COUNT_LSB     = 22;
   localparam int PREFIX_SUPPORT_BIT       = 21;
   localparam int WIDE_FORMAT_BIT          = 20;
   localparam int BUFFER_FLUSH_LSB         = 18;
   localparam int HINT_COMPLETER_LSB       = 12;
   localparam int LATENCY_REPORT_BIT       = 11;
   localparam int RELAXED_PASSING_BIT      = 10;
   localparam int WIDE_CAS_BIT             = 9;
   localparam int ATOMIC64_BIT             = 8;
   localparam int ATOMIC32_BIT             = 7;
   localparam int ATOMIC_ROUTING_BIT       = 6;
   localparam int ALT_ROUTING_FORWARD_BIT  = 5;
   localparam int TIMEOUT_DISABLE_BIT      = 4;
   localparam int TIMEOUT_RANGES_LSB       = 0;

   // processing hint completer encodings
   localparam logic [1:0] HINT_NONE     = 2'h0;
   localparam logic [1:0] HINT_BASIC    = 2'h1;
   localparam logic [1:0] HINT_RESERVED = 2'h2;
   localparam logic [1:0] HINT_BOTH     = 2'h3;

   // ==========================================================
   // own control and status fields, and the wide bit of the tlp format field
   localparam int CTRL_CLEAR_COUNT_BIT   = 0;
   localparam int STAT_SEEN_BIT          = 0;
   localparam int STAT_LAST_COUNT_LSB    = 4;
   localparam int FMT_WIDE_BIT           = 2;

   // ==========================================================
   // reset values
   localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
   localparam logic [2:0]  RESET_COUNT3  = 3'h0;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic       valid;
      logic [2:0] fmt;
      logic [2:0] prefix_count;
      logic [7:0] tag;
   } rx_tlp_t;

   typedef struct packed {
      logic       accepted;
      logic       malformed;
      logic [2:0] prefix_count;
      logic [7:0] tag;
   } rx_verdict_t;

   typedef struct packed {
      logic       read;
      logic       write;
      logic [7:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } bus_req_t;

endpackage

// ===== rtl/rx_prefix_guard.sv
// module: judges each received tlp header against the advertised prefix and format limits
`timescale 1ns/100ps
`default_nettype none

module rx_prefix_guard
(
   input  wire logic                  i_clock,            // 200 MHz core clock
   input  wire logic                  i_rst,              // synchronous reset, active high
   input  wire dev_caps_pkg::rx_tlp_t i_tlp,              // header descriptor from receive path
   input  wire logic [2:0]            i_allowed_prefixes, // most prefixes accepted per tlp
   input  wire logic                  i_wide_format,      // three-bit format field decoded
   output var  dev_caps_pkg::rx_verdict_t o_verdict       // registered verdict, one cycle later
);

   // ==========================================================
   // decision
   wire logic too_many_prefixes;
   wire logic bad_format;
   wire logic reject;

   assign too_many_prefixes = i_tlp.prefix_count > i_allowed_prefixes; // [RL2]
   // a two-bit decoder cannot see the top format bit, so a set one is unparseable
   assign bad_format = ~i_wide_format & i_tlp.fmt[dev_caps_pkg::FMT_WIDE_BIT]; // [RL4]
   assign reject = too_many_prefixes | bad_format;

   // ==========================================================
   // verdict register
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_verdict <= '0;
      end
      else
      begin
         o_verdict.accepted     <= i_tlp.valid & ~reject;
         o_verdict.malformed    <= i_tlp.valid & reject; // [RL2]
         o_verdict.prefix_count <= i_tlp.prefix_count;
         o_verdict.tag          <= i_tlp.tag;
      end
   end

endmodule

`default_nettype wire

// ===== rtl/device_caps_two_regs.sv
// module: device capabilities two register, avalon slave and receive prefix policing
//
// Function
// (RL1) bits 23:22 report the most end-to-end prefixes accepted in one tlp.
// (RL2) a received tlp with more prefixes than reported is marked malformed.
// (RL3) bit 21 reads one when prefixed tlps are accepted, else zero.
// (RL4) bit 20 reads one for a three-bit format field, zero for two-bit.
// (RL5) bits 19:18 report a fixed buffer flush support level.
// (RL6) bits 13:12 report hint completer level; reserved 10b never reported.
// (RL7) bit 11 reads one when latency tolerance reporting is implemented.
// (RL8) relaxed passing, atomic routing and forwarding bits always read zero.
// (RL9) bit 9 reads one exactly when 128-bit compare-and-swap completes.
// (RL10) bit 8 reads one exactly when 64-bit atomics complete.
// (RL11) bit 7 reads one exactly when 32-bit atomics complete.
// (RL12) bit 4 reads one when timeout disable exists; required for requesters.
// (RL13) bits 3:0 report fixed supported completion timeout ranges.
// (RL14) register is read-only; writes ignored, reserved bits read zero.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module device_caps_two_regs
#(
   parameter logic [1:0] MAX_PREFIX_COUNT     = 2'h1, // prefixes accepted per tlp
   parameter logic       PREFIX_SUPPORT       = 1'b1, // prefixed tlps accepted
   parameter logic       WIDE_FORMAT          = 1'b1, // three-bit format field
   parameter logic [1:0] BUFFER_FLUSH_LEVEL   = 2'h0, // buffer flush support level
   parameter logic [1:0] HINT_COMPLETER_LEVEL = 2'h0, // hint completer encoding
   parameter logic       LATENCY_REPORT       = 1'b0, // latency reporting present
   parameter logic       WIDE_CAS_COMPLETER   = 1'b0, // 128-bit cas completer
   parameter logic       ATOMIC64_COMPLETER   = 1'b0, // 64-bit atomic completer
   parameter logic       ATOMIC32_COMPLETER   = 1'b0, // 32-bit atomic completer
   parameter logic       TIMEOUT_DISABLE      = 1'b1, // timeout disable present
   parameter logic       ISSUES_OWN_REQUESTS  = 1'b1, // endpoint masters requests
   parameter logic [3:0] TIMEOUT_RANGES       = 4'h0, // supported timeout ranges
   parameter int         COUNT_W              = 16    // malformed counter width
)
(
   input  wire logic                  i_clock,       // 200 MHz clock
   input  wire logic                  i_rst,         // synchronous reset, active high
   input  wire logic [7:0]            i_address,     // avalon byte address
   input  wire logic                  i_read,        // avalon read request
   input  wire logic                  i_write,       // avalon write request
   input  wire logic [3:0]            i_byteenable,  // avalon byte enables
   input  wire logic [31:0]           i_writedata,   // avalon write data
   output var  logic [31:0]           o_readdata,    // avalon read data, registered
   output logic                       o_waitrequest, // avalon stall
   input  wire dev_caps_pkg::rx_tlp_t i_rx_tlp,      // received tlp header descriptor
   output var  dev_caps_pkg::rx_verdict_t o_rx_verdict // verdict per tlp, registered
);

   // ==========================================================
   // capability word, fixed at elaboration
   wire logic [1:0]  hint_level;
   wire logic        timeout_disable_bit;
   wire logic [2:0]  allowed_prefixes;
   logic      [31:0] cap_word;

   // a reserved encoding is folded to no support rather than advertised
   assign hint_level = (HINT_COMPLETER_LEVEL == dev_caps_pkg::HINT_RESERVED) ?
                       dev_caps_pkg::HINT_NONE : HINT_COMPLETER_LEVEL; // [RL6]

   // a requesting endpoint must offer timeout disable whatever the strap says
   assign timeout_disable_bit = TIMEOUT_DISABLE | ISSUES_OWN_REQUESTS; // [RL12]

   // without prefix support no prefix at all is tolerated
   assign allowed_prefixes = PREFIX_SUPPORT ? {1'b0, MAX_PREFIX_COUNT} : 3'h0; // [RL2]

   always_comb
   begin
      cap_word = dev_caps_pkg::RESET_WORD; // [RL14]
      cap_word[dev_caps_pkg::MAX_PREFIX_COUNT_LSB +: 2] = MAX_PREFIX_COUNT; // [RL1]
      cap_word[dev_caps_pkg::PREFIX_SUPPORT_BIT] = PREFIX_SUPPORT; // [RL3]
      cap_word[dev_caps_pkg::WIDE_FORMAT_BIT] = WIDE_FORMAT; // [RL4]
      cap_word[dev_caps_pkg::BUFFER_FLUSH_LSB +: 2] = BUFFER_FLUSH_LEVEL; // [RL5]
      cap_word[dev_caps_pkg::HINT_COMPLETER_LSB +: 2] = hint_level; // [RL6]
      cap_word[dev_caps_pkg::LATENCY_REPORT_BIT] = LATENCY_REPORT; // [RL7]
      cap_word[dev_caps_pkg::RELAXED_PASSING_BIT] = 1'b0; // [RL8]
      cap_word[dev_caps_pkg::WIDE_CAS_BIT] = WIDE_CAS_COMPLETER; // [RL9]
      cap_word[dev_caps_pkg::ATOMIC64_BIT] = ATOMIC64_COMPLETER; // [RL10]
      cap_word[dev_caps_pkg::ATOMIC32_BIT] = ATOMIC32_COMPLETER; // [RL11]
      cap_word[dev_caps_pkg::ATOMIC_ROUTING_BIT] = 1'b0; // [RL8]
      cap_word[dev_caps_pkg::ALT_ROUTING_FORWARD_BIT] = 1'b0; // [RL8]
      cap_word[dev_caps_pkg::TIMEOUT_DISABLE_BIT] = timeout_disable_bit; // [RL12]
      cap_word[dev_caps_pkg::TIMEOUT_RANGES_LSB +: 4] = TIMEOUT_RANGES; // [RL13]
   end

   // ==========================================================
   // receive policing
   dev_caps_pkg::rx_verdict_t verdict;

   rx_prefix_guard u_guard
   (
      .i_clock            (i_clock),
      .i_rst              (i_rst),
      .i_tlp              (i_rx_tlp),
      .i_allowed_prefixes (allowed_prefixes),
      .i_wide_format      (WIDE_FORMAT),
      .o_verdict          (verdict)
   );

   assign o_rx_verdict = verdict;

   // ==========================================================
   // bus request carrier
   dev_caps_pkg::bus_req_t req;

   assign req.read       = i_read;
   assign req.write      = i_write;
   assign req.address    = i_address;
   assign req.byteenable = i_byteenable;
   assign req.writedata  = i_writedata;

   // ==========================================================
   // bus handshake: every access stalls one cycle, then completes
   typedef enum logic [1:0]
   {
      BUS_IDLE   = 2'b00,
      BUS_ANSWER = 2'b01
   } bus_state_t;

   bus_state_t bus_state_r;
   bus_state_t bus_state_nxt;

   wire logic req_any;
   wire logic req_first;
   wire logic req_done;

   assign req_any   = req.read | req.write;
   assign req_first = req_any & (bus_state_r == BUS_IDLE);
   assign req_done  = req_any & (bus_state_r == BUS_ANSWER);

   always_comb
   begin
      case (bus_state_r)
         BUS_IDLE:
         begin
            bus_state_nxt = req_any ? BUS_ANSWER : BUS_IDLE;
         end
         BUS_ANSWER:
         begin
            bus_state_nxt = BUS_IDLE;
         end
         default:
         begin
            bus_state_nxt = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         bus_state_r <= BUS_IDLE;
      end
      else
      begin
         bus_state_r <= bus_state_nxt;
      end
   end

   assign o_waitrequest = req_any & ~req_done;

   // ==========================================================
   // address decode
   wire logic sel_cap;
   wire logic sel_count;
   wire logic sel_control;
   wire logic sel_status;

   assign sel_cap     = req.address == dev_caps_pkg::DEVICE_CAPABILITIES_TWO_OFS;
   assign sel_count   = req.address == dev_caps_pkg::MALFORMED_COUNT_OFS;
   assign sel_control = req.address == dev_caps_pkg::RX_CONTROL_OFS;
   assign sel_status  = req.address == dev_caps_pkg::RX_STATUS_OFS;

   // writes land once, on the completing edge; a write to the
   // capability word decodes to nothing and so changes nothing
   wire logic wr_take;
   wire logic clear_count;
   wire logic clear_seen;

   assign wr_take     = req_done & req.write;
   assign clear_count = wr_take & sel_control & req.byteenable[0] &
                        req.writedata[dev_caps_pkg::CTRL_CLEAR_COUNT_BIT];
   assign clear_seen  = wr_take & sel_status & req.byteenable[0] &
                        req.writedata[dev_caps_pkg::STAT_SEEN_BIT];

   // ==========================================================
   // malformed statistics
   logic [COUNT_W-1:0] malformed_count_r;
   logic [COUNT_W-1:0] malformed_count_nxt;
   logic               seen_r;
   logic               seen_nxt;
   logic [2:0]         last_count_r;
   logic [2:0]         last_count_nxt;

   wire logic count_full;

   // saturate so a flood of bad tlps never wraps back to a small value
   assign count_full = &malformed_count_r;

   always_comb
   begin
      malformed_count_nxt = malformed_count_r;
      if (clear_count)
      begin
         malformed_count_nxt = '0;
      end
      // an event in the clearing cycle is counted, not lost
      if (verdict.malformed)
      begin
         if (clear_count)
         begin
            malformed_count_nxt = COUNT_W'(1);
         end
         else if (!count_full)
         begin
            malformed_count_nxt = malformed_count_r + COUNT_W'(1);
         end
      end
   end

   always_comb
   begin
      seen_nxt       = seen_r;
      last_count_nxt = last_count_r;
      if (clear_seen)
      begin
         seen_nxt = 1'b0;
      end
      if (verdict.malformed)
      begin
         seen_nxt       = 1'b1;
         last_count_nxt = verdict.prefix_count;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         malformed_count_r <= '0;
         seen_r            <= 1'b0;
         last_count_r      <= dev_caps_pkg::RESET_COUNT3;
      end
      else
      begin
         malformed_count_r <= malformed_count_nxt;
         seen_r            <= seen_nxt;
         last_count_r      <= last_count_nxt;
      end
   end

   // ==========================================================
   // read data
   wire logic [31:0] count_word;
   logic      [31:0] status_word;
   wire logic [31:0] read_word;

   assign count_word = 32'(malformed_count_r);

   always_comb
   begin
      status_word = dev_caps_pkg::RESET_WORD;
      status_word[dev_caps_pkg::STAT_SEEN_BIT] = seen_r;
      status_word[dev_caps_pkg::STAT_LAST_COUNT_LSB +: 3] = last_count_r;
   end

   // control reads zero: its only bit is a self-clearing command
   assign read_word = sel_cap    ? cap_word : // [RL14]
                      sel_count  ? count_word :
                      sel_status ? status_word :
                      dev_caps_pkg::RESET_WORD;

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_readdata <= dev_caps_pkg::RESET_WORD;
      end
      else if (req_first & req.read)
      begin
         o_readdata <= read_word;
      end
   end

endmodule

`default_nettype wire

// ===== tb/device_caps_two_chk.sv
// checker: bus timing, capability fields and prefix verdicts of device_caps_two_regs
`timescale 1ns/100ps
`default_nettype none
module device_caps_two_chk
#(
   parameter logic [1:0] MAX_PREFIX_COUNT = 2'h1, // prefixes accepted per tlp
   parameter logic       PREFIX_SUPPORT   = 1'b1, // prefixed tlps accepted
   parameter logic       WIDE_FORMAT      = 1'b1  // three-bit format field
)
(
   input wire logic                      i_clock,       // core clock
   input wire logic                      i_rst,         // synchronous reset
   input wire logic [7:0]                i_address,     // bus address
   input wire logic                      i_read,        // bus read
   input wire logic                      i_write,       // bus write
   input wire logic [31:0]               o_readdata,    // bus read data
   input wire logic                      o_waitrequest, // bus stall
   input wire dev_caps_pkg::rx_tlp_t     i_rx_tlp,      // received descriptor
   input wire dev_caps_pkg::rx_verdict_t o_rx_verdict   // verdict
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // ==========================================================
   // helpers
   wire logic [2:0] allowed  = PREFIX_SUPPORT ? {1'b0, MAX_PREFIX_COUNT} : 3'h0;
   wire logic       req      = i_read || i_write;
   wire logic       cap_done = i_read && !o_waitrequest && i_address == dev_caps_pkg::DEVICE_CAPABILITIES_TWO_OFS;
   wire logic       bad      = i_rx_tlp.valid && (i_rx_tlp.prefix_count > allowed || (!WIDE_FORMAT && i_rx_tlp.fmt[2]));
   // ==========================================================
   // assertions
   a_first_stall: assert property (req && !$past(req) |-> o_waitrequest)
      else $error("new request not stalled");
   a_one_wait: assert property (req && o_waitrequest |=> !o_waitrequest)
      else $error("stall longer than one cycle");
   a_idle_nostall: assert property (!req |-> !o_waitrequest)
      else $error("stall without request");
   a_reserved_zero: assert property (cap_done |-> o_readdata[31:24] == 8'h00 && o_readdata[17:14] == 4'h0)
      else $error("reserved capability bits not zero");
   a_prefix_fields: assert property (cap_done |-> o_readdata[23:22] == MAX_PREFIX_COUNT
      && o_readdata[21] == PREFIX_SUPPORT && o_readdata[20] == WIDE_FORMAT)
      else $error("prefix or format field wrong");
   a_hint_legal: assert property (cap_done |-> o_readdata[13:12] != dev_caps_pkg::HINT_RESERVED)
      else $error("reserved hint encoding reported");
   a_fixed_zero: assert property (cap_done |-> !o_readdata[10] && !o_readdata[6] && !o_readdata[5])
      else $error("inapplicable feature bit set");
   a_malformed_pulse: assert property (bad |=> o_rx_verdict.malformed && !o_rx_verdict.accepted
      && o_rx_verdict.tag == $past(i_rx_tlp.tag))
      else $error("excess prefixes not marked malformed");
   a_accept_pulse: assert property (i_rx_tlp.valid && !bad |=> o_rx_verdict.accepted && !o_rx_verdict.malformed
      && o_rx_verdict.prefix_count == $past(i_rx_tlp.prefix_count))
      else $error("legal tlp not accepted");
   a_verdict_quiet: assert property (!i_rx_tlp.valid |=> !o_rx_verdict.accepted && !o_rx_verdict.malformed)
      else $error("verdict without descriptor");
   c_cap_read: cover property (cap_done);
   c_malformed: cover property (bad);
   c_write_done: cover property (i_write && !o_waitrequest);
endmodule

bind device_caps_two_regs device_caps_two_chk #(.MAX_PREFIX_COUNT(MAX_PREFIX_COUNT), .PREFIX_SUPPORT(PREFIX_SUPPORT),
   .WIDE_FORMAT(WIDE_FORMAT)) i_device_caps_two_chk (.i_clock(i_clock), .i_rst(i_rst), .i_address(i_address),
   .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
   .i_rx_tlp(i_rx_tlp), .o_rx_verdict(o_rx_verdict));
`default_nettype wire

// ===== tb/tlp_source.sv
// partner: host-side source of received tlp header descriptors
`timescale 1ns/100ps
`default_nettype none
module tlp_source
(
   input  wire logic                  i_clock, // core clock
   output var  dev_caps_pkg::rx_tlp_t o_tlp    // descriptor towards the device
);
   initial o_tlp = '0;
   task automatic send(input logic [2:0] fmt, input logic [2:0] cnt, input logic [7:0] tag);
      o_tlp <= {1'b1, fmt, cnt, tag};
      @(posedge i_clock);
   endtask
   // fields invert while idle so a stale header never looks current
   task automatic idle();
      o_tlp <= {1'b0, ~o_tlp.fmt, ~o_tlp.prefix_count, ~o_tlp.tag};
      @(posedge i_clock);
   endtask
endmodule
`default_nettype wire

// ===== tb/device_caps_two_regs_tb_top.sv
// testbench: capability register reads and receive prefix policing
`timescale 1ns/100ps
`default_nettype none
module device_caps_two_regs_tb_top;
   // ==========================================================
   // clock, reset and design
   localparam logic [31:0] CAP_WORD = 32'h00A0_001A; // word for the parameter set below
   logic                      i_clock      = 1'b0;
   logic                      i_rst        = 1'b1;
   logic [7:0]                i_address    = 8'h00;
   logic                      i_read       = 1'b0;
   logic                      i_write      = 1'b0;
   logic [3:0]                i_byteenable = 4'h0;
   logic [31:0]               i_writedata  = 32'h0000_0000;
   logic [31:0]               o_readdata;
   logic                      o_waitrequest;
   dev_caps_pkg::rx_tlp_t     i_rx_tlp;
   dev_caps_pkg::rx_verdict_t o_rx_verdict;
   logic [31:0]               exp_q[$];
   logic [31:0]               ver_q[$];
   logic [31:0]               seed;
   logic [2:0]                last_bad;
   int                        fails    = 0;
   int                        compares = 0;
   int                        mcount   = 0;
   always #2.5 i_clock = ~i_clock;
   // reserved hint code and a cleared disable strap exercise both folds; prefix count, format and timeout ranges are also set
   device_caps_two_regs #(.MAX_PREFIX_COUNT(2'h2), .WIDE_FORMAT(1'b0), .HINT_COMPLETER_LEVEL(2'h2),
      .TIMEOUT_DISABLE(1'b0), .TIMEOUT_RANGES(4'hA))
      i_device_caps_two_regs (.i_clock(i_clock), .i_rst(i_rst), .i_address(i_address),
      .i_read(i_read), .i_write(i_write), .i_byteenable(i_byteenable), .i_writedata(i_writedata),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_rx_tlp(i_rx_tlp), .o_rx_verdict(o_rx_verdict));
   tlp_source i_tlp_source (.i_clock(i_clock), .o_tlp(i_rx_tlp));
   // ==========================================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // request held until the rising edge that samples waitrequest low, released only then
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      i_read       <= !wr;
      i_write      <= wr;
      i_address    <= a;
      i_writedata  <= d;
      i_byteenable <= 4'hF;
      @(posedge i_clock);
      while (o_waitrequest !== 1'b0 && n < 50)
      begin
         @(posedge i_clock);
         n++;
      end
      if (o_waitrequest !== 1'b0)
      begin
         fails++;
         final_report();
      end
      i_read  <= 1'b0;
      i_write <= 1'b0;
      @(posedge i_clock);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0000_0000);
   endtask
   task automatic tlp(input logic [2:0] f, input logic [2:0] c, input logic [7:0] t);
      logic bad;
      bad = c > 3'h2 || f[2];
      ver_q.push_back(32'({!bad, bad, c, t}));
      if (bad)
      begin
         mcount++;
         last_bad = c;
      end
      i_tlp_source.send(f, c, t);
   endtask
   // ==========================================================
   // monitor: results against the oldest note
   // read data taken at the completing rising edge, as the master does
   always @(posedge i_clock)
   begin
      if (i_read === 1'b1 && o_waitrequest === 1'b0)
         chk(o_readdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEAD_BEEF);
      if (o_rx_verdict.accepted === 1'b1 || o_rx_verdict.malformed === 1'b1)
         chk(32'(o_rx_verdict), ver_q.size() > 0 ? ver_q.pop_front() : 32'hFFFF_FFFF);
   end
   // ==========================================================
   // main sequence
   initial
   begin
      seed = $urandom(32'hF58F);
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      rd(dev_caps_pkg::DEVICE_CAPABILITIES_TWO_OFS, CAP_WORD);
      bus(1'b1, dev_caps_pkg::DEVICE_CAPABILITIES_TWO_OFS, 32'hFFFF_FFFF);
      rd(dev_caps_pkg::DEVICE_CAPABILITIES_TWO_OFS, CAP_WORD);
      rd(8'h80, 32'h0000_0000);
      $display("test capability word done");
      for (int i = 0; i < 9; i++)
         tlp(i == 8 ? 3'h4 : 3'h0, 3'(i), 8'(i));
      for (int i = 0; i < 32; i++)
      begin
         tlp(3'($urandom), 3'($urandom), 8'($urandom));
         if ($urandom % 2)
            i_tlp_source.idle();
      end
      i_tlp_source.idle();
      @(posedge i_clock);
      rd(dev_caps_pkg::MALFORMED_COUNT_OFS, 32'(mcount));
      rd(dev_caps_pkg::RX_STATUS_OFS, {25'h0, last_bad, 3'h0, 1'b1});
      bus(1'b1, dev_caps_pkg::RX_CONTROL_OFS, 32'h0000_0001);
      rd(dev_caps_pkg::MALFORMED_COUNT_OFS, 32'h0000_0000);
      rd(dev_caps_pkg::RX_CONTROL_OFS, 32'h0000_0000);
      bus(1'b1, dev_caps_pkg::RX_STATUS_OFS, 32'h0000_0001);
      rd(dev_caps_pkg::RX_STATUS_OFS, {25'h0, last_bad, 4'h0});
      $display("test prefix policing done");
      repeat (2) @(posedge i_clock);
      chk(32'(exp_q.size() + ver_q.size()), 32'h0000_0000);
      final_report();
   end
endmodule
`default_nettype wire
